// [inc/fds_defines.svh]
// Purpose: constants of the fractional divider control block
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are register indices on the address port
`ifndef FDS_DEFINES_SVH
`define FDS_DEFINES_SVH
// ==========================================================
// register offsets
`define FDS_FRAC_HI_ADDR 8'h00
`define FDS_SHARED_ADDR 8'h01
`define FDS_MOD_LO_ADDR 8'h02
`define FDS_INT_ADDR 8'h03
`define FDS_NSHAPE_CTRL_ADDR 8'h04
`define FDS_CP_CTRL_ADDR 8'h05
`define FDS_ACQ_CTRL_ADDR 8'h06
`define FDS_STATUS_ADDR 8'h07
// ==========================================================
// field positions
`define FDS_BLEED_BIT 2
`define FDS_NSHAPE_PD_BIT 4
`define FDS_ACQ_BIT 0
// ==========================================================
// reset values
`define FDS_FRAC_HI_RST 8'h00
`define FDS_SHARED_RST 8'h02
`define FDS_MOD_LO_RST 8'h71
`define FDS_INT_RST 8'h00
`define FDS_NSHAPE_CTRL_RST 8'h10
`define FDS_CP_CTRL_RST 8'h00
`define FDS_ACQ_CTRL_RST 8'h00
// ==========================================================
// ratio, bandwidth codes and timing
`define FDS_INT_OFFSET 8'h50
`define FDS_BW_50K 2'h0
`define FDS_BW_125K 2'h1
`define FDS_BW_250K 2'h2
`define FDS_CLK_PERIOD_NS 100
`define FDS_CAL_TIME_NS 10000
`define FDS_CAL_CYCLES (`FDS_CAL_TIME_NS / `FDS_CLK_PERIOD_NS)
`endif

// [inc/fds_pkg.sv]
// Purpose: types of the fractional divider control block
// Assumes: nothing
// Notes: one-hot calibration states
package fds_pkg;
  typedef enum logic [2:0] {
    FDS_IDLE = 3'b001,
    FDS_CAL = 3'b010,
    FDS_DONE = 3'b100
  } fds_cal_state_type;
endpackage

// [src/fds_top.sv]
// Purpose: fractional-N feedback control with third-order modulator
// Assumes: fb_edge_i is a one-cycle pulse per feedback divider edge
// Notes: registers on a plain strobe port, read data one cycle later
//
// Design decisions made here: the register addresses and the strobed register port.
`include "fds_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fds_top
  import fds_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic fb_edge_i,
  input wire logic spread_spectrum_pin_i,
  input wire logic max_bandwidth_pin_i,
  output logic [7:0] ratio_o,
  output logic [2:0] offset_o,
  output logic bleed_o,
  output logic [1:0] bw_sel_o,
  output logic [4:0] band_o,
  output logic cal_busy_o
);
  // ========================================================
  // reset release
  logic rst_s1_q;
  logic rst_b_q;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q <= rst_s1_q;
    end
  end

  // ========================================================
  // register file
  logic [7:0] frac_hi_q;
  logic [7:0] shared_q;
  logic [7:0] mod_lo_q;
  logic [7:0] int_q;
  logic [7:0] nshape_ctrl_q;
  logic [7:0] cp_ctrl_q;
  logic [7:0] acq_ctrl_q;
  logic [7:0] rdata_q;
  logic [1:0] rep_q;

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr_i && (addr_i == a);
  endfunction

  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      frac_hi_q <= `FDS_FRAC_HI_RST;
      shared_q <= `FDS_SHARED_RST;
      mod_lo_q <= `FDS_MOD_LO_RST;
      int_q <= `FDS_INT_RST;
      nshape_ctrl_q <= `FDS_NSHAPE_CTRL_RST;
      cp_ctrl_q <= `FDS_CP_CTRL_RST;
      acq_ctrl_q <= `FDS_ACQ_CTRL_RST;
    end else begin
      if (wr_hit(`FDS_FRAC_HI_ADDR)) frac_hi_q <= wdata_i;
      if (wr_hit(`FDS_SHARED_ADDR)) shared_q <= wdata_i;
      if (wr_hit(`FDS_MOD_LO_ADDR)) mod_lo_q <= wdata_i;
      // six-bit field, upper bits read as zero
      if (wr_hit(`FDS_INT_ADDR)) int_q <= {2'h0, wdata_i[5:0]};
      if (wr_hit(`FDS_NSHAPE_CTRL_ADDR)) begin
        nshape_ctrl_q <= wdata_i & 8'h10;
      end
      if (wr_hit(`FDS_CP_CTRL_ADDR)) cp_ctrl_q <= wdata_i & 8'h04;
      if (wr_hit(`FDS_ACQ_CTRL_ADDR)) acq_ctrl_q <= wdata_i & 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `FDS_FRAC_HI_ADDR: rdata_q <= frac_hi_q;
        `FDS_SHARED_ADDR: rdata_q <= shared_q;
        `FDS_MOD_LO_ADDR: rdata_q <= mod_lo_q;
        `FDS_INT_ADDR: rdata_q <= int_q;
        `FDS_NSHAPE_CTRL_ADDR: rdata_q <= nshape_ctrl_q;
        `FDS_CP_CTRL_ADDR: rdata_q <= cp_ctrl_q;
        `FDS_ACQ_CTRL_ADDR: rdata_q <= acq_ctrl_q;
        `FDS_STATUS_ADDR: rdata_q <= {rep_q, cal_busy_o, band_o};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // ========================================================
  // word assembly
  logic [11:0] modulus_word;
  logic [11:0] fraction_word;
  logic nshape_pd;
  assign modulus_word = {shared_q[3:0], mod_lo_q};
  assign fraction_word = {frac_hi_q, shared_q[7:4]};
  assign nshape_pd = nshape_ctrl_q[`FDS_NSHAPE_PD_BIT];

  // ========================================================
  // bleed and loop bandwidth
  logic bleed_q;
  logic [1:0] bw_q;
  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      bleed_q <= 1'b0;
      bw_q <= `FDS_BW_50K;
    end else begin
      bleed_q <= cp_ctrl_q[`FDS_BLEED_BIT];
      if (!spread_spectrum_pin_i) begin
        bw_q <= `FDS_BW_50K;
      end else if (max_bandwidth_pin_i) begin
        bw_q <= `FDS_BW_250K;
      end else begin
        bw_q <= `FDS_BW_125K;
      end
    end
  end
  assign bleed_o = bleed_q;
  assign bw_sel_o = bw_q;

  // ========================================================
  // band calibration
  localparam logic [7:0] CalCycles = 8'(`FDS_CAL_CYCLES);
  fds_cal_state_type cal_q;
  logic [7:0] cal_cnt_q;
  logic [4:0] band_q;
  logic acq_prev_q;
  logic acq_fall;
  logic [8:0] band_prod;
  // field 0..51 maps onto 0..31
  assign band_prod = {3'h0, int_q[5:0]} * 9'd5;
  assign acq_fall = acq_prev_q && !acq_ctrl_q[`FDS_ACQ_BIT];

  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      acq_prev_q <= 1'b0;
    end else begin
      acq_prev_q <= acq_ctrl_q[`FDS_ACQ_BIT];
    end
  end

  // reset release counts as power-up: state starts in calibration
  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      cal_q <= FDS_CAL;
      cal_cnt_q <= 8'h00;
      band_q <= 5'h00;
    end else begin
      case (cal_q)
        FDS_IDLE: begin
          cal_q <= FDS_DONE;
        end
        FDS_CAL: begin
          if (cal_cnt_q == CalCycles - 8'h01) begin
            cal_q <= FDS_DONE;
            cal_cnt_q <= 8'h00;
            band_q <= band_prod[7:3];
          end else begin
            cal_cnt_q <= cal_cnt_q + 8'h01;
          end
        end
        FDS_DONE: begin
          if (acq_fall) begin
            cal_q <= FDS_CAL;
            cal_cnt_q <= 8'h00;
          end
        end
        default: begin
          cal_q <= FDS_CAL;
          cal_cnt_q <= 8'h00;
        end
      endcase
    end
  end
  assign band_o = band_q;
  // one-hot: the calibration bit is itself the flop output
  assign cal_busy_o = cal_q[1];

  // ========================================================
  // third-order multistage modulator, stepped once per feedback edge (fb_edge_i)
  // base ratio is raised by one so the offset fits -4..+3
  logic [11:0] acc1_q;
  logic [11:0] acc2_q;
  logic [11:0] acc3_q;
  logic c2_d1_q;
  logic c3_d1_q;
  logic c3_d2_q;
  logic [12:0] s1;
  logic [12:0] s2;
  logic [12:0] s3;
  logic c1;
  logic c2;
  logic c3;
  logic [2:0] off_d;
  logic [7:0] ratio_q;
  logic [2:0] off_q;
  logic [7:0] int_ratio_b;

  assign int_ratio_b = int_q + `FDS_INT_OFFSET;
  assign s1 = {1'b0, acc1_q} + {1'b0, fraction_word};
  assign c1 = (s1 >= {1'b0, modulus_word});
  assign s2 = {1'b0, acc2_q} + {1'b0, (c1 ? s1[11:0] - modulus_word
                                          : s1[11:0])};
  assign c2 = (s2 >= {1'b0, modulus_word});
  assign s3 = {1'b0, acc3_q} + {1'b0, (c2 ? s2[11:0] - modulus_word
                                          : s2[11:0])};
  assign c3 = (s3 >= {1'b0, modulus_word});
  // c1 + (c2 - c2') + (c3 - 2c3' + c3'') - 1
  assign off_d = 3'({2'h0, c1} + {2'h0, c2} - {2'h0, c2_d1_q}
                    + {2'h0, c3} - {1'h0, c3_d1_q, 1'b0}
                    + {2'h0, c3_d2_q} - 3'h1);

  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      acc1_q <= 12'h000;
      acc2_q <= 12'h000;
      acc3_q <= 12'h000;
      c2_d1_q <= 1'b0;
      c3_d1_q <= 1'b0;
      c3_d2_q <= 1'b0;
      ratio_q <= `FDS_INT_OFFSET;
      off_q <= 3'h0;
    end else if (nshape_pd) begin
      acc1_q <= 12'h000;
      acc2_q <= 12'h000;
      acc3_q <= 12'h000;
      c2_d1_q <= 1'b0;
      c3_d1_q <= 1'b0;
      c3_d2_q <= 1'b0;
      ratio_q <= int_ratio_b;
      off_q <= 3'h0;
    end else if (fb_edge_i) begin
      acc1_q <= c1 ? s1[11:0] - modulus_word : s1[11:0];
      acc2_q <= c2 ? s2[11:0] - modulus_word : s2[11:0];
      acc3_q <= c3 ? s3[11:0] - modulus_word : s3[11:0];
      c2_d1_q <= c2;
      c3_d1_q <= c3;
      c3_d2_q <= c3_d1_q;
      off_q <= off_d;
      ratio_q <= int_ratio_b + 8'h01 + {{5{off_d[2]}}, off_d};
    end
  end
  assign ratio_o = ratio_q;
  assign offset_o = off_q;

  // ========================================================
  // repeat length factor of the code sequence
  always_ff @(posedge clock_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rep_q <= 2'h0;
    end else begin
      rep_q <= {(modulus_word % 12'd3) == 12'd0,
                !modulus_word[0]};
    end
  end

  // ========================================================
  // checks
  property p_bleed;
    @(posedge clock_i) disable iff (!rst_b_q)
      wr_hit(`FDS_CP_CTRL_ADDR) |-> ##2
        bleed_o == $past(wdata_i[`FDS_BLEED_BIT], 2);
  endproperty
  a_bleed: assert property (p_bleed) else $error("bleed mismatch");

  property p_bw;
    @(posedge clock_i) disable iff (!rst_b_q)
      ##1 bw_sel_o == (!$past(spread_spectrum_pin_i) ? `FDS_BW_50K :
        $past(max_bandwidth_pin_i) ? `FDS_BW_250K : `FDS_BW_125K);
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth wrong");

  property p_cal_len;
    @(posedge clock_i) disable iff (!rst_b_q)
      $rose(cal_busy_o) |-> cal_busy_o [*8];
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal too short");

  property p_band;
    @(posedge clock_i) disable iff (!rst_b_q)
      $fell(cal_busy_o) |-> band_o == $past(band_prod[7:3]);
  endproperty
  a_band: assert property (p_band) else $error("band wrong");

  property p_acq;
    @(posedge clock_i) disable iff (!rst_b_q)
      (acq_fall && cal_q == FDS_DONE) |=> cal_busy_o;
  endproperty
  a_acq: assert property (p_acq) else $error("no recal");

  property p_int;
    @(posedge clock_i) disable iff (!rst_b_q)
      nshape_pd |=> ratio_o == $past(int_q) + `FDS_INT_OFFSET;
  endproperty
  a_int: assert property (p_int) else $error("integer ratio wrong");

  property p_pd;
    @(posedge clock_i) disable iff (!rst_b_q)
      nshape_pd |=> (offset_o == 3'h0) && (acc1_q == 12'h000);
  endproperty
  a_pd: assert property (p_pd) else $error("modulator not held");

  property p_ratio;
    @(posedge clock_i) disable iff (!rst_b_q)
      (!nshape_pd && fb_edge_i) |=> ratio_o == 8'($past(int_ratio_b)
        + 8'h01 + {{5{offset_o[2]}}, offset_o});
  endproperty
  a_ratio: assert property (p_ratio) else $error("dither ratio wrong");

  property p_words;
    @(posedge clock_i) disable iff (!rst_b_q)
      wr_hit(`FDS_SHARED_ADDR) |=> modulus_word[11:8] == $past(wdata_i[3:0])
        && fraction_word[3:0] == $past(wdata_i[7:4]);
  endproperty
  a_words: assert property (p_words) else $error("word assembly");
endmodule
`default_nettype wire

// [sim/fds_fbdiv_model.sv]
// Purpose: feedback divider edge source seen by the modulator
// Assumes: one pulse every GAP reference cycles while enabled
// Notes: behavioural; the pulse stands one cycle, line low between
`timescale 1ns/1ps
`default_nettype none
module fds_fbdiv_model #(
  parameter int GAP = 4
) (
  input wire logic clock_i,
  input wire logic en_i,
  output logic fb_edge_o
);
  int cnt;
  initial begin
    cnt = 0;
    fb_edge_o = 1'b0;
  end
  // ======================================
  // edge generation
  // stops dead when disabled, as the real divider does when unclocked
  always @(posedge clock_i) begin
    if (en_i && cnt == GAP - 1) begin
      cnt <= 0;
      fb_edge_o <= 1'b1;
    end else begin
      cnt <= en_i ? cnt + 1 : 0;
      fb_edge_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [sim/fds_top_tb_top.sv]
// Purpose: self-checking bench of the fractional divider control
// Assumes: 10 MHz clock, reset held 8 cycles
// Notes: one task per scenario, expectations worked out here
`include "fds_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  n_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module fds_top_tb_top;
  logic clock_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, fb_en = 0;
  logic ss = 0, mx = 0, fb, fb_d1 = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, ratio_o;
  logic [2:0] offset_o;
  logic [1:0] bw_sel_o;
  logic [4:0] band_o;
  logic bleed_o, cal_busy_o;
  int n_errors = 0, cmp_count = 0, edges = 0, sum = 0, bad = 0;
  fds_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fb_edge_i(fb), .spread_spectrum_pin_i(ss),
    .max_bandwidth_pin_i(mx), .ratio_o(ratio_o), .offset_o(offset_o),
    .bleed_o(bleed_o), .bw_sel_o(bw_sel_o), .band_o(band_o),
    .cal_busy_o(cal_busy_o));
  fds_fbdiv_model #(.GAP(4)) fbdiv (.clock_i(clock_i), .en_i(fb_en),
    .fb_edge_o(fb));
  initial forever #50 clock_i = ~clock_i;
  // ======================================
  // edge monitor: ratio lands the cycle after each feedback edge
  always @(posedge clock_i) begin
    fb_d1 <= fb;
    if (fb_d1) begin
      edges <= edges + 1;
      sum <= sum + ratio_o;
      if (ratio_o !== 8'(81 + 19 + {{5{offset_o[2]}}, offset_o}))
        bad <= bad + 1;
    end
  end
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask
  task automatic wait_cal();
    int i;
    for (i = 0; i < 300 && cal_busy_o !== 1'b0; i++) cyc(1);
    if (i == 300) begin
      n_errors++;
      final_report();
    end
  endtask
  // ======================================
  // scenarios
  task automatic t_reset();
    #1;
    `CHK("cal_busy", 1'b1, cal_busy_o)
    wait_cal();
    #1;
    `CHK("band", 5'h00, band_o)
    `CHK("ratio", 8'd80, ratio_o)
    rd(`FDS_MOD_LO_ADDR, 8'h71);
    rd(`FDS_SHARED_ADDR, 8'h02);
    rd(`FDS_NSHAPE_CTRL_ADDR, 8'h10);
    rd(`FDS_STATUS_ADDR, 8'h00);
    rd(8'h08, 8'h00);
  endtask
  task automatic t_bw();
    logic [1:0] ex [4] = '{`FDS_BW_50K, `FDS_BW_50K, `FDS_BW_125K,
      `FDS_BW_250K};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      {ss, mx} <= 2'(i);
      cyc(2);
      #1;
      `CHK("bw_sel", ex[i], bw_sel_o)
    end
  endtask
  task automatic t_cal();
    wr(`FDS_INT_ADDR, 8'h33);
    cyc(3);
    #1;
    `CHK("ratio max", 8'd131, ratio_o)
    wr(`FDS_ACQ_CTRL_ADDR, 8'h01);
    wr(`FDS_ACQ_CTRL_ADDR, 8'h00);
    cyc(1);
    #1;
    `CHK("cal_busy", 1'b1, cal_busy_o)
    wait_cal();
    #1;
    `CHK("band", 5'd31, band_o)
  endtask
  task automatic t_fields();
    wr(`FDS_FRAC_HI_ADDR, 8'h14);
    wr(`FDS_SHARED_ADDR, 8'hd2);
    wr(`FDS_MOD_LO_ADDR, 8'h58);
    rd(`FDS_SHARED_ADDR, 8'hd2);
    rd(`FDS_STATUS_ADDR, 8'hdf);
    wr(`FDS_MOD_LO_ADDR, 8'h71);
    rd(`FDS_STATUS_ADDR, 8'h1f);
  endtask
  task automatic t_frac();
    int i;
    wr(`FDS_INT_ADDR, 8'h13);
    wr(`FDS_CP_CTRL_ADDR, 8'h04);
    wr(`FDS_NSHAPE_CTRL_ADDR, 8'h00);
    cyc(2);
    #1;
    `CHK("bleed", 1'b1, bleed_o)
    @(posedge clock_i);
    edges <= 0;
    sum <= 0;
    bad <= 0;
    fb_en <= 1'b1;
    // one full modulus period of edges
    for (i = 0; i < 3000 && edges < 625; i++) cyc(1);
    fb_en <= 1'b0;
    cyc(3);
    `CHK("edge wait", 1'b1, i < 3000)
    if (i >= 3000) final_report();
    `CHK("pairing", 0, bad)
    `CHK("average", 1'b1, (sum - 62208 <= 3) && (62208 - sum <= 3))
    `CHK("dither", 1'b1, sum != 625 * 99)
  endtask
  task automatic t_int();
    wr(`FDS_FRAC_HI_ADDR, 8'h00);
    wr(`FDS_SHARED_ADDR, 8'h02);
    wr(`FDS_NSHAPE_CTRL_ADDR, 8'h10);
    wr(`FDS_CP_CTRL_ADDR, 8'h00);
    @(posedge clock_i);
    fb_en <= 1'b1;
    cyc(20);
    #1;
    `CHK("ratio", 8'd99, ratio_o)
    `CHK("offset", 3'h0, offset_o)
    `CHK("bleed", 1'b0, bleed_o)
    @(posedge clock_i);
    fb_en <= 1'b0;
  endtask
  initial begin
    cyc(8);
    rst_b_i <= 1'b1;
    cyc(4);
    t_reset();
    t_bw();
    t_cal();
    t_fields();
    t_frac();
    t_int();
    final_report();
  end
endmodule
`default_nettype wire
